// File: ast_pkg.sv
// Shared constants and types for the asynchronous serial transceiver
package ast_pkg;
  // Oversampling: sixteen baud ticks per bit
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_MID = 4'h7;
  // Transmitted frame lengths in bits (start + data + stop)
  localparam logic [3:0] FRAME_LEN8 = 4'hA;
  localparam logic [3:0] FRAME_LEN9 = 4'hB;
  // Bits collected by the receiver after the start bit
  localparam logic [3:0] RX_BITS8 = 4'h9;
  localparam logic [3:0] RX_BITS9 = 4'hA;
  // Baud ticks of continuous mark that make an idle line
  localparam logic [7:0] IDLE_TICKS8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS9 = 8'hB0;
  // Shift register patterns and the closing mark length in bits
  localparam logic [10:0] SHIFT_ONES = 11'h7FF;
  localparam logic [10:0] SHIFT_ZEROS = 11'h000;
  localparam logic [3:0] MARK_LEN = 4'h1;
  // Values after reset
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_TX_DONE = 1'b1;
  localparam logic RST_LINE = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_BAUD_CNT = 16'h0000;
  // Default prescale of the baud generator, in MCLK cycles per step of rate select
  localparam int unsigned BAUD_BASE_DIV = 4;

  typedef enum logic {TXS_IDLE, TXS_SHIFT} ast_tx_e;
  typedef enum logic [1:0] {RXS_IDLE, RXS_START, RXS_DATA} ast_rx_e;
  typedef enum logic [2:0] {K_NONE, K_DATA, K_IDLE, K_BREAK, K_MARK} ast_kind_e;
endpackage

// File: ast_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ast_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and filtered level
  input wire logic din,
  output logic dout
);
  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  always_comb begin
    out_d = out_q;
    // Only the later two stages vote; the first may be metastable
    if (s2_q == s3_q) begin
      out_d = s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= ast_pkg::RST_LINE;
      s2_q <= ast_pkg::RST_LINE;
      s3_q <= ast_pkg::RST_LINE;
      out_q <= ast_pkg::RST_LINE;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

// File: ast_baud.sv
// Shared baud generator: one pulse per sixteenth of a bit time
`timescale 1ns/1ps
`default_nettype none
module ast_baud #(
  parameter int unsigned BASE_DIV = ast_pkg::BAUD_BASE_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Rate select, 32 settings
  input wire logic [4:0] rate_sel,
  output logic tick
);
  logic [15:0] cnt_q, cnt_d, limit;
  logic tick_q, tick_d;

  always_comb begin
    limit = 16'((32'(rate_sel) + 32'd1) * 32'(BASE_DIV) - 32'd1);
    tick_d = 1'b0;
    cnt_d = cnt_q + 16'h0001;
    if (cnt_q >= limit) begin
      cnt_d = ast_pkg::RST_BAUD_CNT;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= ast_pkg::RST_BAUD_CNT;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// File: ast_uart.sv
// Asynchronous serial transceiver: transmitter, receiver, standby wakeup
//
// What this block does
// - Transmit 8 or 9 data bits per char_size_nine; ninth bit from tx_ninth_bit.
// - Enable transmitter, write buffer; an all-ones preamble goes out before data.
// - Data frame gets a zero start bit low and a one stop bit high.
// - Buffer-empty flag sets when the buffer moves into the shift register.
// - Transmit line idles at one when nothing is shifting.
// - Transmit off while idle and buffer empty releases the line at once.
// - Break sends an all-zero character, sized by character length, no framing.
// - Breaks repeat while requested; after the last one a one bit follows.
// - Idle character is all ones, sized by length; used as the preamble.
// - Transmit off mid-transfer releases the line after the last pending character.
// - Transmit re-enabled during the final character queues one preamble.
// - Transmit interrupt comes from the buffer-empty flag under its mask.
// - Done flag sets when everything is empty; interrupt under done_irq_enable.
// - A received character goes to the data buffer and sets rx_full_flag.
// - Ninth received bit lands in rx_ninth_bit in 9-bit mode.
// - Standby suppresses receiver interrupts until a wakeup.
// - Idle-line wakeup after 10 or 11 bit times of continuous ones.
// - Address-mark wakeup on a one in the character's top bit.
// - standby_exit_select chooses which wakeup condition applies.
// - Transmitter and receiver enabled apart, sharing one 32-rate baud generator.
// - char_size_nine one means 9-bit; reset leaves it alone.
// - standby_exit_select one means address mark, zero idle line.
// - Buffer-empty interrupt gated by empty_irq_enable, cleared by reset.
// - Missing stop bit sets frame_err_flag together with rx_full_flag.
`timescale 1ns/1ps
`default_nettype none
module ast_uart #(
  parameter int unsigned BAUD_DIV = ast_pkg::BAUD_BASE_DIV
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Configuration levels
  input wire logic CHAR_SIZE_NINE,
  input wire logic STANDBY_EXIT_SELECT,
  input wire logic [4:0] BAUD_SEL,
  input wire logic TRANSMIT_ON,
  input wire logic RECEIVE_ON,
  input wire logic BREAK_SEND_BIT,
  input wire logic EMPTY_IRQ_ENABLE,
  input wire logic DONE_IRQ_ENABLE,
  input wire logic RX_IRQ_ENABLE,
  // Transmit data buffer write
  input wire logic TX_WRITE,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_NINTH_BIT,
  // Receive data buffer read
  input wire logic RX_READ,
  output logic [7:0] RX_DATA,
  output logic RX_NINTH_BIT,
  // Standby control
  input wire logic RX_STANDBY_SET,
  output logic RX_STANDBY_BIT,
  // Status flags and interrupt requests
  output logic TX_BUFFER_EMPTY_FLAG,
  output logic TX_DONE_FLAG,
  output logic RX_FULL_FLAG,
  output logic FRAME_ERR_FLAG,
  output logic TX_IRQ,
  output logic RX_IRQ,
  // Serial pins
  output logic TX_LINE_O,
  output logic TX_LINE_OE_N,
  input wire logic RX_LINE_PIN
);
  logic tick;
  logic rx_line;

  ////////////////////////////////////////////////////////////////////////////
  // Shared baud generator and pin synchroniser
  ast_baud #(.BASE_DIV(BAUD_DIV)) u_baud (
    .clk(MCLK),
    .rst_n(RSTN),
    .rate_sel(BAUD_SEL),
    .tick(tick)
  );
  ast_sync3 u_rx_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .din(RX_LINE_PIN),
    .dout(rx_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  ast_pkg::ast_tx_e tx_st_q, tx_st_d;
  ast_pkg::ast_kind_e kind;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d, tx_ph_q, tx_ph_d, flen;
  logic [7:0] tx_buf_q, tx_buf_d;
  logic tx_empty_q, tx_empty_d, tx_done_q, tx_done_d;
  logic pre_q, pre_d, brk_q, brk_d, te_q;
  logic tx_o_q, tx_o_d, tx_oe_n_q, tx_oe_n_d, tx_irq_q, tx_irq_d;
  logic load;
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_ph_d = tx_ph_q;
    tx_buf_d = tx_buf_q;
    tx_empty_d = tx_empty_q;
    tx_done_d = tx_done_q;
    pre_d = pre_q;
    brk_d = brk_q;
    load = 1'b0;
    flen = CHAR_SIZE_NINE ? ast_pkg::FRAME_LEN9 : ast_pkg::FRAME_LEN8;
    // What goes next: break, then closing mark, then preamble, then data
    if (BREAK_SEND_BIT && TRANSMIT_ON) begin
      kind = ast_pkg::K_BREAK;
    end else if (brk_q) begin
      kind = ast_pkg::K_MARK;
    end else if (pre_q && TRANSMIT_ON) begin
      kind = ast_pkg::K_IDLE;
    end else if (!tx_empty_q) begin
      // Data already in the buffer still goes out after transmit is dropped
      kind = ast_pkg::K_DATA;
    end else begin
      kind = ast_pkg::K_NONE;
    end
    if (TX_WRITE) begin
      tx_buf_d = TX_DATA;
      tx_empty_d = 1'b0;
      tx_done_d = 1'b0;
    end
    case (tx_st_q)
      ast_pkg::TXS_IDLE: begin
        load = (kind != ast_pkg::K_NONE);
      end
      ast_pkg::TXS_SHIFT: begin
        if (tick) begin
          if (tx_ph_q == ast_pkg::PH_LAST) begin
            tx_ph_d = 4'h0;
            if (tx_left_q == ast_pkg::MARK_LEN) begin
              // Next frame follows back to back with no gap bit
              load = (kind != ast_pkg::K_NONE);
              if (!load) begin
                tx_st_d = ast_pkg::TXS_IDLE;
              end
            end else begin
              tx_sh_d = {1'b1, tx_sh_q[10:1]};
              tx_left_d = tx_left_q - 4'h1;
            end
          end else begin
            tx_ph_d = tx_ph_q + 4'h1;
          end
        end
      end
      default: begin
        tx_st_d = ast_pkg::TXS_IDLE;
      end
    endcase
    if (load) begin
      tx_st_d = ast_pkg::TXS_SHIFT;
      tx_ph_d = 4'h0;
      tx_left_d = flen;
      brk_d = (kind == ast_pkg::K_BREAK);
      tx_done_d = 1'b0;
      case (kind)
        ast_pkg::K_DATA: begin
          if (CHAR_SIZE_NINE) begin
            tx_sh_d = {1'b1, TX_NINTH_BIT, tx_buf_q, 1'b0};
          end else begin
            tx_sh_d = {2'b11, tx_buf_q, 1'b0};
          end
          tx_empty_d = 1'b1;
        end
        ast_pkg::K_IDLE: begin
          tx_sh_d = ast_pkg::SHIFT_ONES;
          pre_d = 1'b0;
        end
        ast_pkg::K_BREAK: begin
          tx_sh_d = ast_pkg::SHIFT_ZEROS;
        end
        ast_pkg::K_MARK: begin
          tx_sh_d = ast_pkg::SHIFT_ONES;
          tx_left_d = ast_pkg::MARK_LEN;
        end
        default: begin
          tx_sh_d = ast_pkg::SHIFT_ONES;
        end
      endcase
    end
    // A fresh enable queues a preamble even mid-character; set beats consume
    if (TRANSMIT_ON && !te_q) begin
      pre_d = 1'b1;
    end
    if (tx_st_q == ast_pkg::TXS_IDLE && !load && tx_empty_q && !pre_q && !TX_WRITE) begin
      tx_done_d = 1'b1;
    end
    tx_o_d = (tx_st_d == ast_pkg::TXS_SHIFT) ? tx_sh_d[0] : 1'b1;
    tx_oe_n_d = !((tx_st_d == ast_pkg::TXS_SHIFT) || TRANSMIT_ON || !tx_empty_d);
    tx_irq_d = (EMPTY_IRQ_ENABLE && tx_empty_d) || (DONE_IRQ_ENABLE && tx_done_d);
  end
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      tx_st_q <= ast_pkg::TXS_IDLE;
      tx_sh_q <= ast_pkg::SHIFT_ONES;
      tx_left_q <= 4'h0;
      tx_ph_q <= 4'h0;
      tx_buf_q <= ast_pkg::RST_BYTE;
      tx_empty_q <= ast_pkg::RST_TX_EMPTY;
      tx_done_q <= ast_pkg::RST_TX_DONE;
      pre_q <= 1'b0;
      brk_q <= 1'b0;
      te_q <= 1'b0;
      tx_o_q <= ast_pkg::RST_LINE;
      tx_oe_n_q <= 1'b1;
      tx_irq_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_ph_q <= tx_ph_d;
      tx_buf_q <= tx_buf_d;
      tx_empty_q <= tx_empty_d;
      tx_done_q <= tx_done_d;
      pre_q <= pre_d;
      brk_q <= brk_d;
      te_q <= TRANSMIT_ON;
      tx_o_q <= tx_o_d;
      tx_oe_n_q <= tx_oe_n_d;
      tx_irq_q <= tx_irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  ast_pkg::ast_rx_e rx_st_q, rx_st_d;
  logic [3:0] rx_ph_q, rx_ph_d, rx_cnt_q, rx_cnt_d, rx_bits;
  logic [9:0] rx_sh_q, rx_sh_d;
  logic [7:0] rx_data_q, rx_data_d, hi_q, hi_d, idle_lim;
  logic rx_n8_q, rx_n8_d, rx_full_q, rx_full_d, fe_q, fe_d;
  logic sby_q, sby_d, rx_irq_q, rx_irq_d;
  logic done, wake_addr, wake_idle;
  always_comb begin
    rx_st_d = rx_st_q;
    rx_ph_d = rx_ph_q;
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    rx_data_d = rx_data_q;
    rx_n8_d = rx_n8_q;
    rx_full_d = rx_full_q;
    fe_d = fe_q;
    sby_d = sby_q;
    done = 1'b0;
    rx_bits = CHAR_SIZE_NINE ? ast_pkg::RX_BITS9 : ast_pkg::RX_BITS8;
    idle_lim = CHAR_SIZE_NINE ? ast_pkg::IDLE_TICKS9 : ast_pkg::IDLE_TICKS8;
    case (rx_st_q)
      ast_pkg::RXS_IDLE: begin
        if (tick && !rx_line) begin
          rx_st_d = ast_pkg::RXS_START;
          rx_ph_d = 4'h0;
        end
      end
      ast_pkg::RXS_START: begin
        if (tick) begin
          if (rx_ph_q == ast_pkg::PH_MID) begin
            // A start bit gone high by mid-bit was a glitch
            rx_st_d = rx_line ? ast_pkg::RXS_IDLE : ast_pkg::RXS_DATA;
            rx_ph_d = 4'h0;
            rx_cnt_d = 4'h0;
          end else begin
            rx_ph_d = rx_ph_q + 4'h1;
          end
        end
      end
      ast_pkg::RXS_DATA: begin
        if (tick) begin
          if (rx_ph_q == ast_pkg::PH_LAST) begin
            rx_ph_d = 4'h0;
            rx_sh_d = {rx_line, rx_sh_q[9:1]};
            rx_cnt_d = rx_cnt_q + 4'h1;
            if (rx_cnt_d == rx_bits) begin
              done = 1'b1;
              rx_st_d = ast_pkg::RXS_IDLE;
            end
          end else begin
            rx_ph_d = rx_ph_q + 4'h1;
          end
        end
      end
      default: begin
        rx_st_d = ast_pkg::RXS_IDLE;
      end
    endcase
    if (!RECEIVE_ON) begin
      rx_st_d = ast_pkg::RXS_IDLE;
      done = 1'b0;
    end
    // Top data bit sits at index 8 in both character lengths
    wake_addr = done && sby_q && STANDBY_EXIT_SELECT && rx_sh_d[8];
    wake_idle = sby_q && !STANDBY_EXIT_SELECT && (hi_q >= idle_lim);
    hi_d = hi_q;
    if (!rx_line) begin
      hi_d = 8'h00;
    end else if (tick && hi_q < idle_lim) begin
      hi_d = hi_q + 8'h01;
    end
    if (RX_READ) begin
      rx_full_d = 1'b0;
      fe_d = 1'b0;
    end
    // Characters for other listeners are dropped while in standby
    if (done && (!sby_q || wake_addr)) begin
      if (CHAR_SIZE_NINE) begin
        rx_data_d = rx_sh_d[7:0];
        rx_n8_d = rx_sh_d[8];
      end else begin
        rx_data_d = rx_sh_d[8:1];
      end
      rx_full_d = 1'b1;
      fe_d = !rx_sh_d[9];
    end
    if (wake_addr || wake_idle) begin
      sby_d = 1'b0;
    end
    if (RX_STANDBY_SET) begin
      sby_d = 1'b1;
    end
    rx_irq_d = RX_IRQ_ENABLE && RECEIVE_ON && rx_full_d && !sby_d;
  end
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      rx_st_q <= ast_pkg::RXS_IDLE;
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 10'h000;
      rx_data_q <= ast_pkg::RST_BYTE;
      rx_n8_q <= 1'b0;
      rx_full_q <= 1'b0;
      fe_q <= 1'b0;
      sby_q <= 1'b0;
      hi_q <= 8'h00;
      rx_irq_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_ph_q <= rx_ph_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_data_q <= rx_data_d;
      rx_n8_q <= rx_n8_d;
      rx_full_q <= rx_full_d;
      fe_q <= fe_d;
      sby_q <= sby_d;
      hi_q <= hi_d;
      rx_irq_q <= rx_irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign TX_LINE_O = tx_o_q;
  assign TX_LINE_OE_N = tx_oe_n_q;
  assign TX_BUFFER_EMPTY_FLAG = tx_empty_q;
  assign TX_DONE_FLAG = tx_done_q;
  assign TX_IRQ = tx_irq_q;
  assign RX_DATA = rx_data_q;
  assign RX_NINTH_BIT = rx_n8_q;
  assign RX_FULL_FLAG = rx_full_q;
  assign FRAME_ERR_FLAG = fe_q;
  assign RX_STANDBY_BIT = sby_q;
  assign RX_IRQ = rx_irq_q;
endmodule
`default_nettype wire

// File: ast_uart_asserts.sv
// Port-level concurrent checks for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_uart_asserts (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Control levels and strobes
  input wire logic TRANSMIT_ON,
  input wire logic RECEIVE_ON,
  input wire logic TX_WRITE,
  input wire logic EMPTY_IRQ_ENABLE,
  input wire logic DONE_IRQ_ENABLE,
  input wire logic RX_IRQ_ENABLE,
  // Flags, requests and line
  input wire logic TX_BUFFER_EMPTY_FLAG,
  input wire logic TX_DONE_FLAG,
  input wire logic RX_FULL_FLAG,
  input wire logic FRAME_ERR_FLAG,
  input wire logic RX_STANDBY_BIT,
  input wire logic TX_IRQ,
  input wire logic RX_IRQ,
  input wire logic TX_LINE_O,
  input wire logic TX_LINE_OE_N
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////
  // Three done cycles in a row rule out a character loading on the first
  idle_line_high_a: assert property (TX_DONE_FLAG [*3] |-> TX_LINE_O)
    else $error("transmit line low while done");
  idle_release_a: assert property (
    TX_DONE_FLAG && !TRANSMIT_ON && !TX_WRITE |=> TX_LINE_OE_N)
    else $error("line kept after transmitter off");
  late_release_a: assert property (
    $rose(TX_LINE_OE_N) |-> $past(TX_BUFFER_EMPTY_FLAG) && !$past(TRANSMIT_ON))
    else $error("line released with work pending");
  // Requests are built from the flags' next values, so masks lag one cycle
  tx_irq_a: assert property (TX_IRQ == (
    ($past(EMPTY_IRQ_ENABLE) && TX_BUFFER_EMPTY_FLAG) ||
    ($past(DONE_IRQ_ENABLE) && TX_DONE_FLAG)))
    else $error("transmit request disagrees with flags");
  rx_irq_a: assert property (RX_IRQ == (
    $past(RX_IRQ_ENABLE && RECEIVE_ON) && RX_FULL_FLAG && !RX_STANDBY_BIT))
    else $error("receive request disagrees with flags");
  standby_quiet_a: assert property (RX_STANDBY_BIT [*2] |-> !RX_IRQ)
    else $error("receive request during standby");
  frame_with_full_a: assert property ($rose(FRAME_ERR_FLAG) |-> RX_FULL_FLAG)
    else $error("frame error without full flag");
  write_clears_a: assert property (
    TX_WRITE && TX_BUFFER_EMPTY_FLAG |=> !TX_BUFFER_EMPTY_FLAG && !TX_DONE_FLAG)
    else $error("write left empty or done set");
  done_needs_empty_a: assert property (TX_DONE_FLAG |-> TX_BUFFER_EMPTY_FLAG)
    else $error("done while buffer full");
  cover property ($rose(FRAME_ERR_FLAG));
  cover property ($fell(RX_STANDBY_BIT));
  cover property ($rose(TX_LINE_OE_N));
endmodule

bind ast_uart ast_uart_asserts chk (.*);
`default_nettype wire

// File: ast_remote.sv
// Remote serial device: sends frames and captures transmitted ones
`timescale 1ns/1ps
`default_nettype none
module ast_remote #(
  parameter int BIT = 16
) (
  // Clock and character size
  input wire logic clk,
  input wire logic nine,
  // Serial lines
  input wire logic line,
  output logic rxd
);
  logic [10:0] got;
  int n_got;
  // Samples at bit centres; a break reads as all zeros
  initial begin
    rxd = 1'b1;
    n_got = 0;
    got = '0;
    forever begin
      @(negedge line);
      repeat (BIT / 2) @(posedge clk);
      got = '0;
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
        got[i] = line;
        // No wait after the stop sample, so back-to-back starts are caught
        if (i < (nine ? 10 : 9))
          repeat (BIT) @(posedge clk);
      end
      n_got++;
    end
  end
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxd = f[i];
      repeat (BIT) @(posedge clk);
      #1;
    end
    rxd = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int BT = 16;
  logic MCLK, RSTN, CHAR_SIZE_NINE, STANDBY_EXIT_SELECT, TRANSMIT_ON, RECEIVE_ON;
  logic BREAK_SEND_BIT, EMPTY_IRQ_ENABLE, DONE_IRQ_ENABLE, RX_IRQ_ENABLE, TX_WRITE;
  logic TX_NINTH_BIT, RX_READ, RX_NINTH_BIT, RX_STANDBY_SET, RX_STANDBY_BIT, TX_IRQ;
  logic TX_BUFFER_EMPTY_FLAG, TX_DONE_FLAG, RX_FULL_FLAG, FRAME_ERR_FLAG, RX_IRQ;
  logic TX_LINE_O, TX_LINE_OE_N, RX_LINE_PIN;
  logic [4:0] BAUD_SEL;
  logic [7:0] TX_DATA, RX_DATA;
  int n_fail, cmp_count, n, ng;
  // Released line floats to its pull-up level
  wire logic tx_wire = TX_LINE_OE_N ? 1'b1 : TX_LINE_O;
  ast_uart #(.BAUD_DIV(1)) uut (.*);
  ast_remote #(.BIT(BT)) rem (.clk(MCLK), .nine(CHAR_SIZE_NINE), .line(tx_wire),
    .rxd(RX_LINE_PIN));
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  initial begin
    #200_000;
    n_fail++;
    summarize();
  end
  ////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [11:0] fr(input logic [8:0] d, input logic nine);
    fr = nine ? {2'b01, d, 1'b0} : {3'b001, d[7:0], 1'b0};
  endfunction
  task automatic wr(input logic [7:0] d);
    TX_DATA = d;
    TX_WRITE = 1'b1;
    cyc(1);
    TX_WRITE = 1'b0;
  endtask
  task automatic tx_frame(input logic [11:0] e);
    for (int k = 0; k < 900 && rem.n_got <= ng; k++)
      cyc(1);
    ng++;
    chk("tx frame", e, {1'b0, rem.got});
  endtask
  task automatic rx_chk(input logic [8:0] d, input logic stop, input logic [11:0] e);
    rem.send(d, stop);
    cyc(8);
    chk("rx status", e, {RX_IRQ, RX_STANDBY_BIT, FRAME_ERR_FLAG, RX_FULL_FLAG, RX_DATA});
    RX_READ = 1'b1;
    cyc(1);
    RX_READ = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    {RSTN, CHAR_SIZE_NINE, STANDBY_EXIT_SELECT, TRANSMIT_ON, RECEIVE_ON} = '0;
    {BREAK_SEND_BIT, EMPTY_IRQ_ENABLE, DONE_IRQ_ENABLE, RX_IRQ_ENABLE, TX_WRITE} = '0;
    {TX_NINTH_BIT, RX_READ, RX_STANDBY_SET} = '0;
    BAUD_SEL = 5'h00;
    TX_DATA = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    ng = 0;
    cyc(16);
    RSTN = 1'b1;
    cyc(2);
    chk("reset", 12'h01B, {7'h00, TX_BUFFER_EMPTY_FLAG, TX_DONE_FLAG, RX_FULL_FLAG,
      TX_LINE_OE_N, TX_LINE_O});
    TRANSMIT_ON = 1'b1;
    cyc(1);
    wr(8'hA5);
    cyc(4);
    chk("empty in preamble", 12'h000, {11'h000, TX_BUFFER_EMPTY_FLAG});
    n = 6;
    while (tx_wire === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("preamble", 12'h001, {11'h000, n >= 10 * BT && n <= 10 * BT + 6});
    DONE_IRQ_ENABLE = 1'b1;
    cyc(2);
    chk("empty irq off", 12'h002, {10'h000, TX_BUFFER_EMPTY_FLAG, TX_IRQ});
    EMPTY_IRQ_ENABLE = 1'b1;
    cyc(2);
    chk("empty irq on", 12'h001, {11'h000, TX_IRQ});
    {EMPTY_IRQ_ENABLE, DONE_IRQ_ENABLE} = 2'b00;
    wr(8'h3C);
    tx_frame(fr(9'h0A5, 1'b0));
    tx_frame(fr(9'h03C, 1'b0));
    cyc(20);
    TRANSMIT_ON = 1'b0;
    cyc(2);
    chk("idle release", 12'h003, {10'h000, TX_DONE_FLAG, TX_LINE_OE_N});
    CHAR_SIZE_NINE = 1'b1;
    TX_NINTH_BIT = 1'b1;
    TRANSMIT_ON = 1'b1;
    cyc(1);
    wr(8'h81);
    cyc(2);
    TRANSMIT_ON = 1'b0;
    cyc(2);
    chk("held", 12'h000, {11'h000, TX_LINE_OE_N});
    tx_frame(fr(9'h181, 1'b1));
    cyc(30);
    chk("released", 12'h001, {11'h000, TX_LINE_OE_N});
    TRANSMIT_ON = 1'b1;
    cyc(1);
    wr(8'h42);
    @(negedge tx_wire);
    #1;
    TRANSMIT_ON = 1'b0;
    cyc(3);
    TRANSMIT_ON = 1'b1;
    tx_frame(fr(9'h142, 1'b1));
    cyc(20);
    chk("idle queued", 12'h000, {10'h000, TX_LINE_OE_N, TX_DONE_FLAG});
    CHAR_SIZE_NINE = 1'b0;
    cyc(200);
    BREAK_SEND_BIT = 1'b1;
    @(negedge tx_wire);
    #1;
    cyc(200);
    BREAK_SEND_BIT = 1'b0;
    n = 200;
    while (tx_wire === 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk("break run", 12'h001, {11'h000, n >= 20 * BT - 1 && n <= 20 * BT + 2});
    tx_frame(12'h000);
    cyc(BT / 2);
    chk("mark after", 12'h002, {10'h000, tx_wire, TX_DONE_FLAG});
    TRANSMIT_ON = 1'b0;
    RECEIVE_ON = 1'b1;
    RX_IRQ_ENABLE = 1'b1;
    rx_chk(9'h096, 1'b1, 12'h996);
    rx_chk(9'h055, 1'b0, 12'hB55);
    CHAR_SIZE_NINE = 1'b1;
    rx_chk(9'h1C3, 1'b1, 12'h9C3);
    chk("ninth", 12'h001, {11'h000, RX_NINTH_BIT});
    STANDBY_EXIT_SELECT = 1'b1;
    RX_STANDBY_SET = 1'b1;
    cyc(1);
    RX_STANDBY_SET = 1'b0;
    rx_chk(9'h012, 1'b1, 12'h4C3);
    rx_chk(9'h1AB, 1'b1, 12'h9AB);
    CHAR_SIZE_NINE = 1'b0;
    STANDBY_EXIT_SELECT = 1'b0;
    // Standby entered mid-frame, so the line has not been idle beforehand
    fork
      rem.send(9'h092, 1'b1);
      begin
        cyc(20);
        RX_STANDBY_SET = 1'b1;
        cyc(1);
        RX_STANDBY_SET = 1'b0;
      end
    join
    cyc(8);
    chk("standby held", 12'h002, {10'h000, RX_STANDBY_BIT, RX_IRQ});
    n = 0;
    while (RX_STANDBY_BIT === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("idle wake", 12'h001, {11'h000, n >= 7 * BT && n <= 10 * BT});
    summarize();
  end
endmodule
`default_nettype wire
